// *** hdl/uama_match.sv ***
// given and broadcast address comparator
module uama_match
  import uama_pkg::*;
(
  uama_match_if.comparator m
);

  logic [7:0] broadcast;

  // ==========================================================
  // given address
  // masked bit compare
  assign m.given_hit = (((m.rx_byte ^ m.station) & m.mask) == 8'h00);

  // ==========================================================
  // broadcast address
  // or of address and mask
  assign broadcast = m.station | m.mask;
  // zeros of the broadcast pattern are don't care
  assign m.broadcast_hit = ((m.rx_byte & broadcast) == broadcast);

endmodule : uama_match

// *** hdl/uama_match_if.sv ***
// carrier between the top module and the address comparator
interface uama_match_if;
  logic [7:0] rx_byte;
  logic [7:0] station;
  logic [7:0] mask;
  logic       given_hit;
  logic       broadcast_hit;

  modport owner (
    output rx_byte,
    output station,
    output mask,
    input  given_hit,
    input  broadcast_hit
  );

  modport comparator (
    input  rx_byte,
    input  station,
    input  mask,
    output given_hit,
    output broadcast_hit
  );
endinterface : uama_match_if

// *** hdl/uama_pkg.sv ***
// shared constants and types of the multiprocessor address-match block
package uama_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] REG_STATION      = 8'hA9;
  localparam logic [7:0] REG_STATION_MASK = 8'hB9;
  localparam logic [7:0] REG_CTRL         = 8'hC8;
  localparam logic [7:0] REG_IRQ_STATUS   = 8'hC9;
  localparam logic [7:0] REG_IRQ_MASK     = 8'hCA;
  localparam logic [7:0] REG_RX_DATA      = 8'hCB;
  localparam logic [7:0] REG_RX_INFO      = 8'hCC;
  localparam logic [7:0] REG_LAST_ADDR    = 8'hCD;
  localparam logic [7:0] REG_ACCEPT_CNT   = 8'hCE;
  localparam logic [7:0] REG_DROP_CNT     = 8'hCF;
  localparam logic [7:0] READ_UNMAPPED    = 8'h00;

  // ==========================================================
  // field positions
  localparam int CTRL_FILTER_BIT = 0;
  localparam int CTRL_MODE_LSB   = 1;
  localparam int INFO_RCF_BIT    = 0;
  localparam int INFO_BIT9_BIT   = 1;
  localparam int INFO_SEL_BIT    = 2;
  localparam int IRQ_ACCEPT_BIT  = 0;
  localparam int IRQ_DROP_BIT    = 1;
  localparam int IRQ_FRAME_BIT   = 2;
  localparam int IRQ_OVERRUN_BIT = 3;
  localparam int IRQ_WIDTH       = 4;

  // ==========================================================
  // reset values
  localparam logic [7:0]           STATION_RESET = 8'h00;
  localparam logic [7:0]           MASK_RESET    = 8'h00;
  localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 4'h0;
  localparam logic [7:0]           COUNT_RESET   = 8'h00;

  // ==========================================================
  // serial frame modes
  typedef enum logic [1:0] {
    UAMA_MODE_SYNC8  = 2'b00,
    UAMA_MODE_ASYNC10 = 2'b01,
    UAMA_MODE_ASYNC11_FIXED = 2'b10,
    UAMA_MODE_ASYNC11_TIMER = 2'b11
  } uama_mode_t;

  // ==========================================================
  // whole state of the top module
  typedef struct packed {
    logic [7:0]           station;
    logic [7:0]           mask;
    logic                 filter_en;
    uama_mode_t           mode;
    logic [7:0]           rx_data;
    logic                 rx_bit9;
    logic                 rcf;
    logic                 selected;
    logic [7:0]           last_addr;
    logic [IRQ_WIDTH-1:0] irq_status;
    logic [IRQ_WIDTH-1:0] irq_mask;
    logic [7:0]           accept_cnt;
    logic [7:0]           drop_cnt;
    logic [7:0]           rd_data;
    logic                 irq;
  } uama_state_t;

endpackage : uama_pkg

// *** hdl/uama_top.sv ***
// multiprocessor address recognition for the serial port receiver
// ==========================================================
module uama_top
  import uama_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       srst,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wr_data,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  output logic      [7:0] reg_rd_data,
  // frames from the receive shifter, same clock
  input  wire logic       frame_valid,
  input  wire logic [7:0] frame_data,
  input  wire logic       frame_bit9,
  // status toward the core
  output logic            receive_complete_flag,
  output logic            multiproc_filter_enable,
  output logic            slave_selected,
  output logic            irq
);

  // ==========================================================
  // state
  uama_state_t cur;
  uama_state_t next_state;

  localparam uama_state_t STATE_RESET = '{
    station:    STATION_RESET,
    mask:       MASK_RESET,
    filter_en:  1'b0,
    mode:       UAMA_MODE_SYNC8,
    rx_data:    8'h00,
    rx_bit9:    1'b0,
    rcf:        1'b0,
    selected:   1'b0,
    last_addr:  8'h00,
    irq_status: '0,
    irq_mask:   IRQ_MASK_RESET,
    accept_cnt: COUNT_RESET,
    drop_cnt:   COUNT_RESET,
    rd_data:    8'h00,
    irq:        1'b0
  };

  // ==========================================================
  // address comparator
  uama_match_if match_bus ();

  assign match_bus.rx_byte = frame_data;
  assign match_bus.station = cur.station;
  assign match_bus.mask    = cur.mask;

  uama_match u_match (
    .m (match_bus.comparator)
  );

  // ==========================================================
  // frame classification
  logic addr_hit;
  logic mode_11bit;
  logic mode_10bit;
  logic frame_accept;
  logic frame_is_address;
  logic stop_bad;

  assign addr_hit   = match_bus.given_hit | match_bus.broadcast_hit;
  assign mode_11bit = (cur.mode == UAMA_MODE_ASYNC11_FIXED) || (cur.mode == UAMA_MODE_ASYNC11_TIMER);
  assign mode_10bit = (cur.mode == UAMA_MODE_ASYNC10);
  // in 10-bit mode the ninth bit carries the stop bit
  assign stop_bad   = mode_10bit & ~frame_bit9;
  // address bytes marked by ninth bit
  assign frame_is_address = mode_11bit & frame_bit9;

  always_comb
  begin
    frame_accept = 1'b1;
    if (cur.filter_en)
    begin
      if (mode_11bit)
      begin
        frame_accept = frame_bit9 & addr_hit;
      end
      else if (mode_10bit)
      begin
        frame_accept = frame_bit9 & addr_hit;
      end
      else
      begin
        // synchronous mode has no address byte to check
        frame_accept = 1'b1;
      end
    end
    else
    begin
      frame_accept = 1'b1;
    end
  end

  // ==========================================================
  // register access decode
  logic wr_station;
  logic wr_mask;
  logic wr_ctrl;
  logic wr_irq_mask;
  logic wr_accept_cnt;
  logic wr_drop_cnt;
  logic rd_rx_data;
  logic rd_irq_status;

  assign wr_station    = reg_wr_en && (reg_addr == REG_STATION);
  assign wr_mask       = reg_wr_en && (reg_addr == REG_STATION_MASK);
  assign wr_ctrl       = reg_wr_en && (reg_addr == REG_CTRL);
  assign wr_irq_mask   = reg_wr_en && (reg_addr == REG_IRQ_MASK);
  assign wr_accept_cnt = reg_wr_en && (reg_addr == REG_ACCEPT_CNT);
  assign wr_drop_cnt   = reg_wr_en && (reg_addr == REG_DROP_CNT);
  assign rd_rx_data    = reg_rd_en && (reg_addr == REG_RX_DATA);
  assign rd_irq_status = reg_rd_en && (reg_addr == REG_IRQ_STATUS);

  // ==========================================================
  // next-state logic
  logic [IRQ_WIDTH-1:0] irq_set;
  logic [7:0]           rd_value;

  always_comb
  begin
    next_state = cur;
    irq_set    = '0;
    rd_value   = READ_UNMAPPED;

    // software writes
    if (wr_station)
    begin
      next_state.station = reg_wr_data;
    end
    if (wr_mask)
    begin
      next_state.mask = reg_wr_data;
    end
    if (wr_ctrl)
    begin
      next_state.filter_en = reg_wr_data[CTRL_FILTER_BIT];
      next_state.mode      = uama_mode_t'(reg_wr_data[CTRL_MODE_LSB +: 2]);
    end
    if (wr_irq_mask)
    begin
      next_state.irq_mask = reg_wr_data[IRQ_WIDTH-1:0];
    end
    if (wr_accept_cnt)
    begin
      next_state.accept_cnt = COUNT_RESET;
    end
    if (wr_drop_cnt)
    begin
      next_state.drop_cnt = COUNT_RESET;
    end

    // read side effects come before frame events so a set wins
    if (rd_rx_data)
    begin
      next_state.rcf = 1'b0;
    end
    if (rd_irq_status)
    begin
      next_state.irq_status = '0;
    end

    // frame events
    if (frame_valid)
    begin
      if (frame_accept)
      begin
        if (cur.rcf && !rd_rx_data)
        begin
          // previous byte unread, it is overwritten
          irq_set[IRQ_OVERRUN_BIT] = 1'b1;
        end
        next_state.rx_data    = frame_data;
        next_state.rx_bit9    = frame_bit9;
        next_state.rcf        = 1'b1;
        next_state.accept_cnt = cur.accept_cnt + 8'h01;
        irq_set[IRQ_ACCEPT_BIT] = 1'b1;
      end
      else
      begin
        next_state.drop_cnt = cur.drop_cnt + 8'h01;
        irq_set[IRQ_DROP_BIT] = 1'b1;
      end
      if (stop_bad)
      begin
        irq_set[IRQ_FRAME_BIT] = 1'b1;
      end
      // track whether the last address byte picked this station
      if (frame_is_address)
      begin
        next_state.last_addr = frame_data;
        next_state.selected  = addr_hit;
      end
    end

    next_state.irq_status = next_state.irq_status | irq_set;

    // read data, one cycle after the strobe
    case (reg_addr)
      REG_STATION:      rd_value = cur.station;
      REG_STATION_MASK: rd_value = cur.mask;
      REG_CTRL:         rd_value = {5'h00, cur.mode, cur.filter_en};
      REG_IRQ_STATUS:   rd_value = {4'h0, cur.irq_status};
      REG_IRQ_MASK:     rd_value = {4'h0, cur.irq_mask};
      REG_RX_DATA:      rd_value = cur.rx_data;
      REG_RX_INFO:      rd_value = {5'h00, cur.selected, cur.rx_bit9, cur.rcf};
      REG_LAST_ADDR:    rd_value = cur.last_addr;
      REG_ACCEPT_CNT:   rd_value = cur.accept_cnt;
      REG_DROP_CNT:     rd_value = cur.drop_cnt;
      default:          rd_value = READ_UNMAPPED;
    endcase
    next_state.rd_data = reg_rd_en ? rd_value : 8'h00;

    // level interrupt from sticky status and mask
    next_state.irq = |(next_state.irq_status & next_state.irq_mask);
  end

  // ==========================================================
  // state register
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      cur <= STATE_RESET;
    end
    else
    begin
      cur <= next_state;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rd_data             = cur.rd_data;
  assign receive_complete_flag   = cur.rcf;
  assign multiproc_filter_enable = cur.filter_en;
  assign slave_selected          = cur.selected;
  assign irq                     = cur.irq;

endmodule : uama_top

// *** tb/tb_top.sv ***
// self-checking bench for the address-match top module
module tb_top
  import uama_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // stimulus, model and checks
  logic       core_clk = 1'b0;
  logic       srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wr_data = 8'h00;
  logic       reg_wr_en = 1'b0;
  logic       reg_rd_en = 1'b0;
  wire  [7:0] reg_rd_data;
  wire        frame_valid, frame_bit9, receive_complete_flag, multiproc_filter_enable, slave_selected, irq;
  wire  [7:0] frame_data;
  int         seed = 81;
  int         error_cnt = 0;
  int         compares = 0;
  logic [7:0] m_sta = 8'h00;
  logic [7:0] m_msk = 8'h00;
  logic       m_filt = 1'b0;
  logic [1:0] m_mode = 2'b00;
  // model of selection, last address, counters and sticky status
  int         m_acc = 0;
  int         m_drop = 0;
  logic       m_sel = 1'b0;
  logic       m_b9 = 1'b0;
  logic [7:0] m_last = 8'h00;
  logic [3:0] m_st = 4'h0;
  always #20 core_clk = ~core_clk;
  uama_top dut (.core_clk, .srst, .reg_addr, .reg_wr_data, .reg_wr_en, .reg_rd_en, .reg_rd_data, .frame_valid,
    .frame_data, .frame_bit9, .receive_complete_flag, .multiproc_filter_enable, .slave_selected, .irq);
  uama_master_model m (.core_clk, .frame_valid, .frame_data, .frame_bit9);
  task check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr    <= a;
    reg_wr_data <= d;
    reg_wr_en   <= 1'b1;
    @(posedge core_clk);
    reg_wr_en   <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    #1;
    v = reg_rd_data;
  endtask : rd
  task cfg(input logic filt, input logic [1:0] mode);
    m_filt = filt;
    m_mode = mode;
    wr(REG_CTRL, {5'h00, mode, filt});
  endtask : cfg
  function automatic logic exp_hit(input logic [7:0] b);
    return (((b ^ m_sta) & m_msk) == 8'h00) || ((b & (m_sta | m_msk)) == (m_sta | m_msk));
  endfunction : exp_hit
  function automatic logic exp_accept(input logic [7:0] b, input logic bit9);
    return !m_filt || m_mode == 2'b00 || (bit9 && exp_hit(b));
  endfunction : exp_accept
  task automatic frame(input logic [7:0] b, input logic bit9);
    logic       e;
    logic [7:0] v;
    e = exp_accept(b, bit9);
    m_st = m_st | {1'b0, (m_mode == 2'b01) && !bit9, !e, e};
    // address bytes of the 11-bit modes move the selection, filter on or off
    if (m_mode[1] && bit9)
    begin
      m_sel  = exp_hit(b);
      m_last = b;
    end
    if (e)
    begin
      m_acc++;
      m_b9 = bit9;
    end
    else
      m_drop++;
    m.send(b, bit9, {$random(seed)} % 3);
    @(posedge core_clk);
    #1;
    check({7'h00, receive_complete_flag}, {7'h00, e});
    if (e)
    begin
      rd(REG_RX_DATA, v);
      check(v, b);
      check({7'h00, receive_complete_flag}, 8'h00);
    end
    check({7'h00, slave_selected}, {7'h00, m_sel});
    check({7'h00, multiproc_filter_enable}, {7'h00, m_filt});
    rd(REG_RX_INFO, v);
    check(v, {5'h00, m_sel, m_b9, 1'b0});
    rd(REG_LAST_ADDR, v);
    check(v, m_last);
    rd(REG_ACCEPT_CNT, v);
    check(v, 8'(m_acc));
    rd(REG_DROP_CNT, v);
    check(v, 8'(m_drop));
  endtask : frame
  task tally_and_finish;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #800000;
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    logic [7:0] v;
    logic [7:0] b;
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    rd(REG_STATION, v);
    check(v, 8'h00);
    rd(REG_STATION_MASK, v);
    check(v, 8'h00);
    rd(8'h10, v);
    check(v, 8'h00);
    cfg(1'b1, 2'b11);
    frame(8'($random(seed)), 1'b1);
    $display("test reset_values done");
    m_sta = 8'hA4;
    m_msk = 8'hFA;
    wr(REG_STATION, m_sta);
    wr(REG_STATION_MASK, m_msk);
    rd(REG_STATION, v);
    check(v, 8'hA4);
    rd(REG_STATION_MASK, v);
    check(v, 8'hFA);
    frame(8'hA0, 1'b1);
    frame(8'hA3, 1'b1);
    frame(8'hFE, 1'b1);
    frame(8'hA0, 1'b0);
    $display("test given_broadcast done");
    // mixed modes: half the bytes forced onto the given address
    for (int r = 0; r < 8; r++)
    begin
      m_sta = 8'($random(seed));
      m_msk = 8'($random(seed));
      wr(REG_STATION, m_sta);
      wr(REG_STATION_MASK, m_msk);
      cfg(1'b1, 2'(r));
      for (int i = 0; i < 8; i++)
      begin
        b = 8'($random(seed));
        frame(i[0] ? b : ((b & ~m_msk) | (m_sta & m_msk)), 1'($random(seed)));
      end
    end
    $display("test random_modes done");
    cfg(1'b0, 2'b11);
    for (int i = 0; i < 6; i++)
      frame(8'($random(seed)), 1'b0);
    $display("test filter_off done");
    rd(REG_IRQ_STATUS, v);
    check(v, {4'h0, m_st});
    wr(REG_IRQ_MASK, 8'h01);
    frame(8'h5A, 1'b0);
    check({7'h00, irq}, 8'h01);
    rd(REG_IRQ_STATUS, v);
    check(v, 8'h01);
    @(posedge core_clk);
    #1;
    check({7'h00, irq}, 8'h00);
    wr(REG_IRQ_MASK, 8'h00);
    frame(8'h3C, 1'b0);
    check({7'h00, irq}, 8'h00);
    $display("test interrupt done");
    tally_and_finish();
  end
endmodule : tb_top

// *** tb/uama_assertions.sv ***
// port-level checker for the multiprocessor address-match top module
module uama_assertions
  import uama_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic       reg_wr_en,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  input wire logic       frame_valid,
  input wire logic [7:0] frame_data,
  input wire logic       frame_bit9,
  input wire logic       receive_complete_flag,
  input wire logic       multiproc_filter_enable,
  input wire logic       slave_selected,
  input wire logic       irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // shadow of the programmed registers
  logic [7:0] sta;
  logic [7:0] msk;
  logic [2:0] ctl;
  logic       hit;
  logic       acc;
  always_ff @(posedge core_clk)
  begin
    sta <= srst ? 8'h00 : (reg_wr_en && reg_addr == REG_STATION) ? reg_wr_data : sta;
    msk <= srst ? 8'h00 : (reg_wr_en && reg_addr == REG_STATION_MASK) ? reg_wr_data : msk;
    ctl <= srst ? 3'h0 : (reg_wr_en && reg_addr == REG_CTRL) ? reg_wr_data[2:0] : ctl;
  end
  assign hit = (((frame_data ^ sta) & msk) == 8'h00) || ((frame_data & (sta | msk)) == (sta | msk));
  assign acc = !ctl[0] || ctl[2:1] == 2'b00 || (frame_bit9 && hit);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_rd(logic [7:0] a);
    reg_rd_en && reg_addr == a;
  endsequence
  sequence s_frame_clean;
    frame_valid && !receive_complete_flag && !reg_rd_en;
  endsequence
  a_rd_idle_zero: assert property (!$past(reg_rd_en) |-> reg_rd_data == 8'h00) else $error("read data not idle");
  a_station_read: assert property (s_rd(REG_STATION) |=> reg_rd_data == $past(sta)) else $error("station readback");
  a_mask_read: assert property (s_rd(REG_STATION_MASK) |=> reg_rd_data == $past(msk)) else $error("mask readback");
  a_filter_copy: assert property (reg_wr_en && reg_addr == REG_CTRL |=> multiproc_filter_enable == $past(reg_wr_data[0]))
    else $error("filter enable copy");
  a_match_sets: assert property (frame_valid && acc |=> receive_complete_flag) else $error("accepted frame lost");
  a_miss_drops: assert property ((s_frame_clean and !acc) |=> !receive_complete_flag)
    else $error("refused frame flagged");
  a_filter_off_all: assert property (frame_valid && !multiproc_filter_enable |=> receive_complete_flag)
    else $error("unfiltered frame lost");
  a_select_track: assert property (frame_valid && ctl[0] && ctl[2] && frame_bit9 |=> slave_selected == $past(hit))
    else $error("selection wrong");
  a_rd_clears: assert property ((s_rd(REG_RX_DATA) and !frame_valid) |=> !receive_complete_flag)
    else $error("flag not cleared");
endmodule : uama_assertions

bind uama_top uama_assertions u_chk (.core_clk, .srst, .reg_addr, .reg_wr_data, .reg_wr_en, .reg_rd_en, .reg_rd_data,
  .frame_valid, .frame_data, .frame_bit9, .receive_complete_flag, .multiproc_filter_enable, .slave_selected, .irq);

// *** tb/uama_master_model.sv ***
// serial master model: hands completed frames to the receiver side
module uama_master_model
(
  output logic       frame_valid,
  output logic [7:0] frame_data,
  output logic       frame_bit9,
  input  wire logic  core_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // frame delivery, prompt or after idle cycles
  initial
  begin
    frame_valid = 1'b0;
    frame_data  = 8'h00;
    frame_bit9  = 1'b0;
  end
  task automatic send(input logic [7:0] b, input logic bit9, input int gap);
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    frame_valid <= 1'b1;
    frame_data  <= b;
    frame_bit9  <= bit9;
    @(posedge core_clk);
    frame_valid <= 1'b0;
    // stale lines show the inverse so old data never looks valid
    frame_data  <= ~b;
    frame_bit9  <= ~bit9;
  endtask : send
endmodule : uama_master_model
